// ---- hw/clock_reset_pkg.sv ----
// Purpose: Shared constants and types of the clock generation and reset unit.
// Assumes: Registers sit in one register bank reached through the serial slave.
// Notes:   Frequencies are in MHz and times in the unit that their names give.
package clock_reset_pkg;

	// Register offsets.
	localparam logic [7:0] SOFT_RESET_OFFSET   = 8'h24;
	localparam logic [7:0] CLOCK_DIV_OFFSET    = 8'h25;
	localparam logic [7:0] PLL_CONTROL_OFFSET  = 8'h4a;
	localparam logic [7:0] REF_DIVIDER_OFFSET  = 8'h4d;
	localparam logic [7:0] FB_MULTIPLIER_OFFSET = 8'h4e;

	// Field positions.
	localparam int SOFT_RESET_BIT   = 0;
	localparam int HALVER_BIT       = 5;
	localparam int DDIV_LSB         = 0;
	localparam int PLL_POWER_DOWN_BIT       = 5;
	localparam int PLL_SKIP_BIT     = 4;

	// Values after reset.
	localparam logic       SOFT_RESET_RESET    = 1'b0;
	localparam logic       HALVER_RESET        = 1'b1;
	localparam logic [2:0] DDIV_RESET          = 3'b000;
	localparam logic       PLL_POWER_DOWN_RESET        = 1'b1;
	localparam logic       PLL_SKIP_RESET      = 1'b1;
	localparam logic [7:0] REF_DIVIDER_RESET   = 8'h03;
	localparam logic [7:0] FB_MULTIPLIER_RESET = 8'h08;

	// Double-rate divider codes.
	localparam logic [2:0] DDIV_BY_ONE  = 3'b000;
	localparam logic [2:0] DDIV_BY_TWO  = 3'b010;
	localparam logic [2:0] DDIV_BY_FOUR = 3'b100;

	// Frequencies and counts.
	localparam int         REF_CLOCK_MHZ     = 27;
	localparam int         VCO_LIMIT_MHZ     = 72;
	localparam int         SYNC_HOLD_PCLKS   = 16;
	localparam int         HARD_RESET_MCLKS  = 8;
	localparam int         PLL_LOCK_US       = 300;

	// Slave address; the value is arbitrary.
	localparam logic [6:0] SLAVE_ADDRESS     = 7'h2a;

	// Clock configuration as it goes to the analogue PLL and the dividers.
	typedef struct packed {
		logic       pll_power_down;
		logic       pll_skip_select;
		logic       pixel_clock_halver;
		logic [2:0] double_rate_clock_divider;
		logic [7:0] reference_divider;
		logic [7:0] feedback_multiplier;
	} clock_cfg_t;

	typedef enum logic [8:0] {
		BUS_IDLE = 9'b000000001,
		BUS_ADDR = 9'b000000010,
		BUS_AACK = 9'b000000100,
		BUS_PTR  = 9'b000001000,
		BUS_PACK = 9'b000010000,
		BUS_WDAT = 9'b000100000,
		BUS_WACK = 9'b001000000,
		BUS_RDAT = 9'b010000000,
		BUS_RACK = 9'b100000000
	} bus_state_t;

	typedef enum logic [2:0] {
		SR_IDLE  = 3'b001,
		SR_SCL   = 3'b010,
		SR_PIXEL = 3'b100
	} soft_reset_state_t;

endpackage

// ---- hw/clock_enable_divider.sv ----
// Purpose: Turns source clock ticks into pixel and double-rate pixel enables.
// Assumes: src_tick is a one-cycle pulse per source clock rising edge.
// Notes:   Reserved divider codes fall back to divide by one.
`timescale 1ns/1ps
module clock_enable_divider
	import clock_reset_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Source and settings
	input  wire logic       src_tick,
	input  wire logic       halver,
	input  wire logic [2:0] ddiv,
	// Enables
	output logic            pclk_en,
	output logic            ppclk_en
);
	import clock_reset_pkg::*;

	logic [1:0] tick_count;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_count <= 2'h0;
		end else if (src_tick) begin
			tick_count <= tick_count + 2'h1;
		end
	end

	// Halver cleared gives every other source tick, set gives each one.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pclk_en <= 1'b0;
		end else begin
			pclk_en <= src_tick & (halver | tick_count[0]);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ppclk_en <= 1'b0;
		end else begin
			case (ddiv)
				DDIV_BY_TWO:  ppclk_en <= src_tick & tick_count[0];
				DDIV_BY_FOUR: ppclk_en <= src_tick & (tick_count == 2'h3);
				default:      ppclk_en <= src_tick;
			endcase
		end
	end

endmodule

// ---- hw/clock_reset_unit.sv ----
// Purpose: Clock control registers, pixel clock enables and soft reset sequencing.
// Assumes: rst is the hard reset pin already inverted, held at least eight master clocks.
// Notes:   Clocks are represented as enable pulses on clk; the PLL itself is analogue.
//
// Behaviour
// - The PLL output is reference times multiplier over divider and software keeps it at or below 72 MHz.
// - With the skip bit set the reference replaces the PLL output at the dividers, and the bit resets set.
// - Power-down bit 5 powers the PLL on when clear and down when set, resetting set.
// - The halver bit gives the source over two when clear and the source itself when set, resetting set.
// - The double-rate field gives divide by one, two and four for 000, 010 and 100, resetting 000.
// - Two internal clocks are derived, the pixel clock and the double-rate pixel clock.
// - Hard or soft reset returns every register to its default.
// - Writing one to bit 0 of the soft reset register starts a soft reset.
// - Both resets go low together and stay low for one serial clock period.
// - Then the asynchronous reset releases and the synchronous one stays low 16 more pixel clocks.
`timescale 1ns/1ps
module clock_reset_unit
	import clock_reset_pkg::*;
#(
	parameter int SYNC_HOLD = SYNC_HOLD_PCLKS
)
(
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst,
	// Clock pins
	input  wire logic                       reference_clock_input,
	input  wire logic                       vco_clock_input,
	// Serial register port
	input  wire logic                       scl_in,
	input  wire logic                       sda_in,
	output logic                            sda_out,
	output logic                            sda_oe,
	// PLL control
	output clock_reset_pkg::clock_cfg_t     pll_cfg,
	output logic                            vco_over_limit,
	// Derived clocks
	output logic                            pclk_en,
	output logic                            ppclk_en,
	// Soft reset outputs
	output logic                            async_reset_n,
	output logic                            sync_reset_n
);
	import clock_reset_pkg::*;

	// The hold counter is eight bits wide, so larger holds cannot be served.
	if (SYNC_HOLD < 1 || SYNC_HOLD > 255) begin
		$error("SYNC_HOLD must lie between 1 and 255");
	end

	// Pin synchronisers: stage 1 feeds stage 2 only; stage 3 serves edge detection.
	logic [2:0] ref_sync;
	logic [2:0] vco_sync;
	logic [2:0] scl_sync;
	logic [2:0] sda_sync;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ref_sync <= 3'h0;
			vco_sync <= 3'h0;
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
		end else begin
			ref_sync <= {ref_sync[1:0], reference_clock_input};
			vco_sync <= {vco_sync[1:0], vco_clock_input};
			scl_sync <= {scl_sync[1:0], scl_in};
			sda_sync <= {sda_sync[1:0], sda_in};
		end
	end

	logic ref_rise;
	logic vco_rise;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic src_tick;

	assign ref_rise  = ref_sync[1] & ~ref_sync[2];
	assign vco_rise  = vco_sync[1] & ~vco_sync[2];
	assign scl_rise  = scl_sync[1] & ~scl_sync[2];
	assign scl_fall  = ~scl_sync[1] & scl_sync[2];
	assign bus_start = scl_sync[1] & scl_sync[2] & ~sda_sync[1] & sda_sync[2];
	assign bus_stop  = scl_sync[1] & scl_sync[2] & sda_sync[1] & ~sda_sync[2];

	// Sampling at 200 MHz limits the usable PLL output to well under 100 MHz, which the
	// 72 MHz ceiling respects. A powered-down PLL yields no ticks unless skipped.
	assign src_tick = pll_cfg.pll_skip_select ? ref_rise :
		(~pll_cfg.pll_power_down & vco_rise);

	// Serial slave.
	bus_state_t  bus_state;
	logic [3:0]  bit_count;
	logic [7:0]  rx_shift;
	logic [7:0]  tx_shift;
	logic [7:0]  reg_ptr;
	logic        read_mode;
	logic        master_nack;
	logic        wr_strobe;
	logic [7:0]  read_value;
	logic        soft_reset_trigger;
	logic        regs_to_default;
	soft_reset_state_t sr_state;

	always_comb begin
		read_value = 8'h00;
		if (reg_ptr == SOFT_RESET_OFFSET) begin
			read_value[SOFT_RESET_BIT] = soft_reset_trigger;
		end else if (reg_ptr == CLOCK_DIV_OFFSET) begin
			read_value[HALVER_BIT] = pll_cfg.pixel_clock_halver;
			read_value[DDIV_LSB +: 3] = pll_cfg.double_rate_clock_divider;
		end else if (reg_ptr == PLL_CONTROL_OFFSET) begin
			read_value[PLL_POWER_DOWN_BIT] = pll_cfg.pll_power_down;
			read_value[PLL_SKIP_BIT] = pll_cfg.pll_skip_select;
		end else if (reg_ptr == REF_DIVIDER_OFFSET) begin
			read_value = pll_cfg.reference_divider;
		end else if (reg_ptr == FB_MULTIPLIER_OFFSET) begin
			read_value = pll_cfg.feedback_multiplier;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_state   <= BUS_IDLE;
			bit_count   <= 4'h0;
			rx_shift    <= 8'h00;
			tx_shift    <= 8'h00;
			reg_ptr     <= 8'h00;
			read_mode   <= 1'b0;
			master_nack <= 1'b0;
			sda_oe      <= 1'b0;
			wr_strobe   <= 1'b0;
		end else begin
			wr_strobe <= 1'b0;
			if (bus_start) begin
				bus_state <= BUS_ADDR;
				bit_count <= 4'h0;
				sda_oe    <= 1'b0;
			end else if (bus_stop) begin
				bus_state <= BUS_IDLE;
				sda_oe    <= 1'b0;
			end else begin
				case (bus_state)
					BUS_ADDR, BUS_PTR, BUS_WDAT: begin
						if (scl_rise) begin
							rx_shift  <= {rx_shift[6:0], sda_sync[1]};
							bit_count <= bit_count + 4'h1;
						end else if (scl_fall && bit_count == 4'h8) begin
							bit_count <= 4'h0;
							sda_oe    <= 1'b1;
							if (bus_state == BUS_ADDR) begin
								read_mode <= rx_shift[0];
								if (rx_shift[7:1] == SLAVE_ADDRESS) begin
									bus_state <= BUS_AACK;
								end else begin
									bus_state <= BUS_IDLE;
									sda_oe    <= 1'b0;
								end
							end else if (bus_state == BUS_PTR) begin
								reg_ptr   <= rx_shift;
								bus_state <= BUS_PACK;
							end else begin
								wr_strobe <= 1'b1;
								bus_state <= BUS_WACK;
							end
						end
					end
					BUS_AACK, BUS_RACK: begin
						if (scl_rise && bus_state == BUS_RACK) begin
							master_nack <= sda_sync[1];
						end else if (scl_fall) begin
							if (read_mode && !(bus_state == BUS_RACK && master_nack)) begin
								sda_oe    <= ~read_value[7];
								tx_shift  <= {read_value[6:0], 1'b0};
								reg_ptr   <= reg_ptr + 8'h01;
								bit_count <= 4'h1;
								bus_state <= BUS_RDAT;
							end else begin
								sda_oe    <= 1'b0;
								bus_state <= read_mode ? BUS_IDLE : BUS_PTR;
							end
						end
					end
					BUS_PACK, BUS_WACK: begin
						if (scl_fall) begin
							sda_oe    <= 1'b0;
							bus_state <= BUS_WDAT;
							if (bus_state == BUS_WACK) begin
								reg_ptr <= reg_ptr + 8'h01;
							end
						end
					end
					BUS_RDAT: begin
						if (scl_fall) begin
							if (bit_count == 4'h8) begin
								sda_oe    <= 1'b0;
								bus_state <= BUS_RACK;
							end else begin
								sda_oe    <= ~tx_shift[7];
								tx_shift  <= {tx_shift[6:0], 1'b0};
								bit_count <= bit_count + 4'h1;
							end
						end
					end
					default: begin
						bus_state <= BUS_IDLE;
					end
				endcase
			end
		end
	end

	// Open drain: the pin is only ever pulled low.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
		end
	end

	// Register file. The soft reset returns it to defaults while the asynchronous phase lasts,
	// but the slave keeps its place so that the acknowledge in flight still completes.
	assign regs_to_default = (sr_state == SR_SCL);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			soft_reset_trigger                <= SOFT_RESET_RESET;
			pll_cfg.pixel_clock_halver        <= HALVER_RESET;
			pll_cfg.double_rate_clock_divider <= DDIV_RESET;
			pll_cfg.pll_power_down            <= PLL_POWER_DOWN_RESET;
			pll_cfg.pll_skip_select           <= PLL_SKIP_RESET;
			pll_cfg.reference_divider         <= REF_DIVIDER_RESET;
			pll_cfg.feedback_multiplier       <= FB_MULTIPLIER_RESET;
		end else if (regs_to_default) begin
			soft_reset_trigger                <= SOFT_RESET_RESET;
			pll_cfg.pixel_clock_halver        <= HALVER_RESET;
			pll_cfg.double_rate_clock_divider <= DDIV_RESET;
			pll_cfg.pll_power_down            <= PLL_POWER_DOWN_RESET;
			pll_cfg.pll_skip_select           <= PLL_SKIP_RESET;
			pll_cfg.reference_divider         <= REF_DIVIDER_RESET;
			pll_cfg.feedback_multiplier       <= FB_MULTIPLIER_RESET;
		end else if (wr_strobe) begin
			if (reg_ptr == SOFT_RESET_OFFSET) begin
				soft_reset_trigger <= rx_shift[SOFT_RESET_BIT];
			end else if (reg_ptr == CLOCK_DIV_OFFSET) begin
				pll_cfg.pixel_clock_halver        <= rx_shift[HALVER_BIT];
				pll_cfg.double_rate_clock_divider <= rx_shift[DDIV_LSB +: 3];
			end else if (reg_ptr == PLL_CONTROL_OFFSET) begin
				pll_cfg.pll_power_down  <= rx_shift[PLL_POWER_DOWN_BIT];
				pll_cfg.pll_skip_select <= rx_shift[PLL_SKIP_BIT];
			end else if (reg_ptr == REF_DIVIDER_OFFSET) begin
				pll_cfg.reference_divider <= rx_shift;
			end else if (reg_ptr == FB_MULTIPLIER_OFFSET) begin
				pll_cfg.feedback_multiplier <= rx_shift;
			end
		end
	end

	// Ratio check: reference times multiplier against the ceiling times divider.
	localparam logic [7:0] REF_MHZ_W   = 8'(REF_CLOCK_MHZ);
	localparam logic [7:0] LIMIT_MHZ_W = 8'(VCO_LIMIT_MHZ);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			vco_over_limit <= 1'b0;
		end else begin
			vco_over_limit <= (16'(REF_MHZ_W) * 16'(pll_cfg.feedback_multiplier)) >
				(16'(LIMIT_MHZ_W) * 16'(pll_cfg.reference_divider));
		end
	end

	// Soft reset sequencer.
	logic       soft_reset_request;
	logic [7:0] pclk_count;
	logic       div_pclk_en;
	logic       div_ppclk_en;

	assign soft_reset_request = wr_strobe && reg_ptr == SOFT_RESET_OFFSET &&
		rx_shift[SOFT_RESET_BIT];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sr_state   <= SR_IDLE;
			pclk_count <= 8'h00;
		end else begin
			case (sr_state)
				SR_IDLE: begin
					if (soft_reset_request) begin
						sr_state <= SR_SCL;
					end
				end
				SR_SCL: begin
					// The write strobe comes at the fall that opens the acknowledge clock,
					// so the next fall closes one whole serial clock period.
					if (scl_fall) begin
						sr_state   <= SR_PIXEL;
						pclk_count <= 8'h00;
					end
				end
				SR_PIXEL: begin
					if (div_pclk_en) begin
						if (pclk_count == 8'(SYNC_HOLD - 1)) begin
							sr_state <= SR_IDLE;
						end else begin
							pclk_count <= pclk_count + 8'h01;
						end
					end
				end
				default: begin
					sr_state <= SR_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			async_reset_n <= 1'b0;
			sync_reset_n  <= 1'b0;
		end else begin
			async_reset_n <= ~(sr_state == SR_SCL || (sr_state == SR_IDLE && soft_reset_request));
			sync_reset_n  <= (sr_state == SR_IDLE) && !soft_reset_request;
		end
	end

	clock_enable_divider i_clock_enable_divider (
		.clk      (clk),
		.rst      (rst),
		.src_tick (src_tick),
		.halver   (pll_cfg.pixel_clock_halver),
		.ddiv     (pll_cfg.double_rate_clock_divider),
		.pclk_en  (div_pclk_en),
		.ppclk_en (div_ppclk_en)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pclk_en  <= 1'b0;
			ppclk_en <= 1'b0;
		end else begin
			pclk_en  <= div_pclk_en;
			ppclk_en <= div_ppclk_en;
		end
	end

endmodule

// ---- verif/clock_reset_unit_props.sv ----
// Purpose: Port-level checks of the clock generation and reset unit.
// Assumes: Serial half-periods of at least four clocks.
// Notes:   Bound to every clock_reset_unit instance.
`timescale 1ns/1ps
module clock_reset_unit_props
	import clock_reset_pkg::*;
#(
	parameter int SYNC_HOLD = SYNC_HOLD_PCLKS
)
(
	// Clock and reset
	input wire logic                        clk,
	input wire logic                        rst,
	// Observed outputs
	input wire clock_reset_pkg::clock_cfg_t pll_cfg,
	input wire logic                        vco_over_limit,
	input wire logic                        pclk_en,
	input wire logic                        ppclk_en,
	input wire logic                        async_reset_n,
	input wire logic                        sync_reset_n
);
	localparam clock_cfg_t CFG_DEFAULT = {PLL_POWER_DOWN_RESET, PLL_SKIP_RESET, HALVER_RESET,
		DDIV_RESET, REF_DIVIDER_RESET, FB_MULTIPLIER_RESET};
	logic [7:0] held_pclks;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			held_pclks <= 8'h00;
		end else if (!async_reset_n) begin
			held_pclks <= 8'h00;
		end else if (!sync_reset_n && pclk_en) begin
			held_pclks <= held_pclks + 8'h01;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	defaults_held_a: assert property (!async_reset_n |=> pll_cfg == CFG_DEFAULT)
		else $error("settings not at defaults after reset");
	resets_together_a: assert property ($fell(async_reset_n) |-> $fell(sync_reset_n))
		else $error("resets did not fall together");
	async_hold_a: assert property ($fell(async_reset_n) |-> !async_reset_n [*8])
		else $error("async reset released too early");
	async_release_a: assert property ($fell(async_reset_n) |-> ##[1:1000] async_reset_n)
		else $error("async reset never released");
	sync_after_a: assert property ($rose(sync_reset_n) |-> async_reset_n)
		else $error("sync reset released before async");
	// The release lands one cycle after the last counted pixel enable pulse.
	sync_count_a: assert property ($rose(sync_reset_n) && $past(async_reset_n) |->
		$past(pclk_en) && held_pclks == SYNC_HOLD)
		else $error("sync reset hold count wrong");
	// A pulse launched before a setting change is not judged by the new setting.
	halver_gap_a: assert property (pclk_en && !pll_cfg.pixel_clock_halver &&
		$past(!pll_cfg.pixel_clock_halver, 2) |=> (!pclk_en || pll_cfg.pixel_clock_halver) [*8])
		else $error("halved pixel enable too frequent");
	quarter_gap_a: assert property (ppclk_en && pll_cfg.double_rate_clock_divider == DDIV_BY_FOUR
		&& $past(pll_cfg.double_rate_clock_divider, 2) == DDIV_BY_FOUR
		|=> (!ppclk_en || pll_cfg.double_rate_clock_divider != DDIV_BY_FOUR) [*8])
		else $error("quartered enable too frequent");
	same_tick_a: assert property (pll_cfg.pixel_clock_halver && $past(pll_cfg) == pll_cfg
		&& $past(pll_cfg, 3) == pll_cfg && pll_cfg.double_rate_clock_divider == DDIV_BY_ONE
		|-> ppclk_en == pclk_en)
		else $error("undivided enables differ");
	no_source_a: assert property ((pll_cfg.pll_power_down && !pll_cfg.pll_skip_select) [*8]
		|-> !pclk_en && !ppclk_en)
		else $error("enables with PLL powered down");
	over_limit_a: assert property (vco_over_limit ==
		($past(pll_cfg.feedback_multiplier) * REF_CLOCK_MHZ >
		$past(pll_cfg.reference_divider) * VCO_LIMIT_MHZ))
		else $error("over limit flag wrong");
	soft_done_c: cover property ($rose(sync_reset_n) && $past(async_reset_n));
	over_limit_c: cover property ($rose(vco_over_limit));
	quarter_c: cover property (ppclk_en && pll_cfg.double_rate_clock_divider == DDIV_BY_FOUR);
endmodule

bind clock_reset_unit clock_reset_unit_props #(.SYNC_HOLD(SYNC_HOLD)) i_clock_reset_unit_props (
	.clk(clk), .rst(rst), .pll_cfg(pll_cfg), .vco_over_limit(vco_over_limit), .pclk_en(pclk_en),
	.ppclk_en(ppclk_en), .async_reset_n(async_reset_n), .sync_reset_n(sync_reset_n));

// ---- verif/clock_source_model.sv ----
// Purpose: Reference oscillator and analogue PLL seen from the unit's clock pins.
// Assumes: Time unit is 1 ns.
// Notes:   Before lock the PLL output toggles every 3 ns, so early use shows up.
`timescale 1ns/1ps
module clock_source_model
	import clock_reset_pkg::*;
#(
	parameter realtime LOCK_NS = 300000.0
)
(
	// Settings from the unit
	input wire clock_reset_pkg::clock_cfg_t cfg,
	// Clock pins
	output logic                            ref_clk,
	output logic                            vco_clk
);
	realtime on_since;
	initial begin
		ref_clk = 1'b0;
		vco_clk = 1'b0;
		on_since = 0.0;
	end
	always #(500.0 / REF_CLOCK_MHZ) ref_clk = ~ref_clk;
	always @(cfg.pll_power_down) on_since = $realtime;
	always begin
		if (cfg.pll_power_down) begin
			vco_clk = 1'b0;
			#1;
		end else if ($realtime - on_since < LOCK_NS) begin
			vco_clk = ~vco_clk;
			#3;
		end else begin
			vco_clk = ~vco_clk;
			#(500.0 * cfg.reference_divider / (REF_CLOCK_MHZ * cfg.feedback_multiplier));
		end
	end
endmodule

// ---- verif/clock_reset_unit_tb.sv ----
// Purpose: Self-checking bench of the clock generation and reset unit.
// Assumes: The serial port is driven as an open-drain bus with a pull-up.
// Notes:   Tick counts allow a couple of ticks for synchroniser phase.
`timescale 1ns/1ps
module clock_reset_unit_tb;
	import clock_reset_pkg::*;
	localparam logic [7:0] WR_ADDR = {SLAVE_ADDRESS, 1'b0};
	localparam int         TICKS = 5 * REF_CLOCK_MHZ;
	logic       clk, rst, scl, m_low, ref_clk, vco_clk, vco_over_limit, pclk_en, ppclk_en;
	logic       sda_out, sda_oe, async_reset_n, sync_reset_n;
	clock_cfg_t pll_cfg;
	int         n_fail, n_compared;
	wire        sda = !(sda_oe || m_low);
	clock_source_model #(.LOCK_NS(2000.0)) i_clock_source_model (.cfg(pll_cfg),
		.ref_clk(ref_clk), .vco_clk(vco_clk));
	clock_reset_unit i_clock_reset_unit (.clk(clk), .rst(rst), .reference_clock_input(ref_clk),
		.vco_clock_input(vco_clk), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.pll_cfg(pll_cfg), .vco_over_limit(vco_over_limit), .pclk_en(pclk_en),
		.ppclk_en(ppclk_en), .async_reset_n(async_reset_n), .sync_reset_n(sync_reset_n));
	initial clk = 1'b0;
	always #2.5 clk = ~clk;
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic near(input string what, input int exp, input int got, input int tol);
		n_compared++;
		if (got < exp - tol || got > exp + tol) begin
			n_fail++;
			$display("ERROR %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic half();
		repeat (8) @(posedge clk);
	endtask
	task automatic put_bit(input logic b, output logic s);
		m_low <= !b;
		half();
		scl <= 1'b1;
		half();
		s = sda;
		scl <= 1'b0;
		half();
	endtask
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
		output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i], s);
			q[i] = s;
		end
		put_bit(last, s);
		ack = !s;
	endtask
	task automatic start();
		m_low <= 1'b0;
		half();
		scl <= 1'b1;
		half();
		m_low <= 1'b1;
		half();
		scl <= 1'b0;
		half();
	endtask
	task automatic stop();
		m_low <= 1'b1;
		half();
		scl <= 1'b1;
		half();
		m_low <= 1'b0;
		half();
	endtask
	task automatic reg_write(input logic [7:0] off, input logic [7:0] data);
		logic [7:0] q;
		logic       a0, a1, a2;
		start();
		xfer(WR_ADDR, 1'b1, q, a0);
		xfer(off, 1'b1, q, a1);
		xfer(data, 1'b1, q, a2);
		stop();
		chk("write acks", 8'h07, {5'h00, a0, a1, a2});
	endtask
	task automatic expect_reg(input string what, input logic [7:0] off, input logic [7:0] exp);
		logic [7:0] q, v;
		logic       a;
		start();
		xfer(WR_ADDR, 1'b1, q, a);
		xfer(off, 1'b1, q, a);
		start();
		xfer(WR_ADDR | 8'h01, 1'b1, q, a);
		xfer(8'hff, 1'b1, v, a);
		stop();
		chk(what, exp, v);
	endtask
	task automatic count_ticks(input int cycles, output int p, output int pp);
		p = 0;
		pp = 0;
		repeat (cycles) begin
			@(posedge clk);
			p += int'(pclk_en === 1'b1);
			pp += int'(ppclk_en === 1'b1);
		end
	endtask
	task automatic t_defaults();
		logic [7:0] q;
		logic       a;
		chk("cfg bits", 8'h07, {5'h00, pll_cfg[21:19]});
		chk("sda out", 8'h00, {7'h00, sda_out});
		expect_reg("trigger", SOFT_RESET_OFFSET, 8'h00);
		expect_reg("divider", CLOCK_DIV_OFFSET, 8'h20);
		expect_reg("pll control", PLL_CONTROL_OFFSET, 8'h30);
		expect_reg("ref divider", REF_DIVIDER_OFFSET, 8'h03);
		expect_reg("multiplier", FB_MULTIPLIER_OFFSET, 8'h08);
		reg_write(8'h30, 8'h5a);
		expect_reg("unmapped", 8'h30, 8'h00);
		start();
		xfer(WR_ADDR ^ 8'h02, 1'b1, q, a);
		stop();
		chk("foreign address ack", 8'h00, {7'h00, a});
	endtask
	task automatic t_dividers();
		logic [7:0] codes [6] = '{8'h20, 8'h22, 8'h24, 8'h23, 8'h00, 8'h04};
		int         p, pp, div;
		foreach (codes[i]) begin
			reg_write(CLOCK_DIV_OFFSET, codes[i]);
			expect_reg("divider", CLOCK_DIV_OFFSET, codes[i]);
			count_ticks(1000, p, pp);
			div = codes[i][2:0] == DDIV_BY_TWO ? 2 : codes[i][2:0] == DDIV_BY_FOUR ? 4 : 1;
			near("pixel ticks", codes[i][5] ? TICKS : TICKS / 2, p, 2);
			near("double rate ticks", TICKS / div, pp, 2);
		end
	endtask
	task automatic t_pll();
		int p, pp;
		reg_write(CLOCK_DIV_OFFSET, 8'h20);
		reg_write(FB_MULTIPLIER_OFFSET, 8'h04);
		chk("over limit 36", 8'h00, {7'h00, vco_over_limit});
		reg_write(PLL_CONTROL_OFFSET, 8'h20);
		count_ticks(1000, p, pp);
		near("ticks powered down", 0, p, 0);
		reg_write(PLL_CONTROL_OFFSET, 8'h00);
		repeat (600) @(posedge clk);
		count_ticks(1000, p, pp);
		near("pll ticks", TICKS * 4 / 3, p, 3);
		reg_write(PLL_CONTROL_OFFSET, 8'h10);
		count_ticks(1000, p, pp);
		near("reference ticks", TICKS, p, 2);
		reg_write(FB_MULTIPLIER_OFFSET, 8'h09);
		chk("over limit 81", 8'h01, {7'h00, vco_over_limit});
		reg_write(FB_MULTIPLIER_OFFSET, 8'h08);
		chk("over limit 72", 8'h00, {7'h00, vco_over_limit});
	endtask
	task automatic t_soft_reset();
		int c;
		reg_write(CLOCK_DIV_OFFSET, 8'h04);
		reg_write(FB_MULTIPLIER_OFFSET, 8'h05);
		fork
			reg_write(SOFT_RESET_OFFSET, 8'h01);
			begin
				for (c = 0; c < 4000 && async_reset_n !== 1'b0; c++) @(posedge clk);
				chk("resets low", 8'h00, {6'h00, async_reset_n, sync_reset_n});
				for (c = 0; c < 4000 && async_reset_n !== 1'b1; c++) @(posedge clk);
				chk("async first", 8'h02, {6'h00, async_reset_n, sync_reset_n});
				c = 0;
				for (int k = 0; k < 4000; k++) begin
					c += int'(pclk_en === 1'b1);
					if (sync_reset_n === 1'b1) break;
					@(posedge clk);
				end
				near("sync hold ticks", SYNC_HOLD_PCLKS, c, 0);
			end
		join
		expect_reg("divider", CLOCK_DIV_OFFSET, 8'h20);
		expect_reg("multiplier", FB_MULTIPLIER_OFFSET, 8'h08);
		expect_reg("trigger", SOFT_RESET_OFFSET, 8'h00);
	endtask
	task automatic t_hard_reset();
		reg_write(CLOCK_DIV_OFFSET, 8'h04);
		reg_write(FB_MULTIPLIER_OFFSET, 8'h05);
		rst <= 1'b1;
		repeat (8) @(posedge ref_clk);
		@(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		chk("hard reset cfg", 8'h07, {5'h00, pll_cfg[21:19]});
		chk("hard reset outs", 8'h03, {6'h00, async_reset_n, sync_reset_n});
		expect_reg("divider", CLOCK_DIV_OFFSET, 8'h20);
		expect_reg("multiplier", FB_MULTIPLIER_OFFSET, 8'h08);
	endtask
	task automatic summarize();
		if (n_fail == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		n_fail = 0;
		n_compared = 0;
		rst = 1'b1;
		scl = 1'b1;
		m_low = 1'b0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		t_defaults();
		t_dividers();
		t_pll();
		t_soft_reset();
		t_hard_reset();
		summarize();
	end
	initial begin
		#300us;
		n_fail++;
		summarize();
	end
endmodule
